// ### verilog/atm_pkg.sv
`default_nettype none
package atm_pkg;

   ////////////////////////////////////////////////////////////////////////
   // widths
   localparam int ADDR_W  = 6;
   localparam int DATA_W  = 8;
   localparam int SEL_W   = 4;
   localparam int DAC_W   = 6;
   localparam int ADC_W   = 4;
   localparam int LEVEL_W = 6;
   localparam int TBUS_W  = 8;
   localparam int TSEL_W  = 3;

   ////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [5:0] ADDR_AUX_SEL = 6'h38;
   localparam logic [5:0] ADDR_DAC_ONE = 6'h39;
   localparam logic [5:0] ADDR_DAC_TWO = 6'h3a;
   localparam logic [5:0] ADDR_ADC     = 6'h3b;
   localparam logic [5:0] ADDR_PROD_A  = 6'h3c;
   localparam logic [5:0] ADDR_PROD_B  = 6'h3d;
   localparam logic [5:0] ADDR_PROD_C  = 6'h3e;
   localparam logic [5:0] ADDR_PROD_D  = 6'h3f;

   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int SEL_FIRST_LSB  = 4;
   localparam int SEL_SECOND_LSB = 0;
   localparam int DAC_LSB        = 0;
   localparam int ADC_I_LSB      = 4;
   localparam int ADC_Q_LSB      = 0;

   ////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] RST_AUX_SEL = 8'h00;
   localparam logic [5:0] RST_DAC     = 6'h00;
   localparam logic [7:0] RST_PROD_A  = 8'h00;
   localparam logic [7:0] RST_PROD_B  = 8'h00;
   localparam logic [7:0] RST_PROD_C  = 8'h03;
   localparam logic [7:0] RST_PROD_D  = 8'h00;
   localparam logic [7:0] READ_ZERO   = 8'h00;

   // pin levels for the logic-valued sources
   localparam logic [5:0] LEVEL_HIGH = 6'h3f;
   localparam logic [5:0] LEVEL_LOW  = 6'h00;
   localparam logic [1:0] ADC_PAD    = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // source select codes
   typedef enum logic [3:0] {
      ATM_SRC_TRISTATE = 4'h0,
      ATM_SRC_DAC      = 4'h1,
      ATM_SRC_CORR     = 4'h2,
      ATM_SRC_RSV3     = 4'h3,
      ATM_SRC_MINLVL   = 4'h4,
      ATM_SRC_ADC_I    = 4'h5,
      ATM_SRC_ADC_Q    = 4'h6,
      ATM_SRC_RSV7     = 4'h7,
      ATM_SRC_PROD8    = 4'h8,
      ATM_SRC_RSV9     = 4'h9,
      ATM_SRC_HIGH     = 4'ha,
      ATM_SRC_LOW      = 4'hb,
      ATM_SRC_TXACT    = 4'hc,
      ATM_SRC_RXACT    = 4'hd,
      ATM_SRC_SUBC     = 4'he,
      ATM_SRC_TBUS     = 4'hf
   } atm_src_e;

   typedef struct packed {
      logic [5:0] corr;
      logic [5:0] min_level;
      logic [3:0] adc_i;
      logic [3:0] adc_q;
   } atm_analog_s;

   typedef struct packed {
      logic tx_active;
      logic rx_active;
      logic subcarrier;
      logic test_bus_bit;
   } atm_flags_s;

   typedef struct packed {
      logic       oe;
      logic [5:0] level;
   } atm_drive_s;

   // shared by both pins so the two fields decode identically
   function automatic atm_drive_s atm_decode(input logic [3:0]  sel,
                                             input logic [5:0]  dac,
                                             input atm_analog_s an,
                                             input atm_flags_s  fl);
      atm_drive_s d;
      d = '{oe: 1'b0, level: LEVEL_LOW};
      unique case (atm_src_e'(sel))
         ATM_SRC_TRISTATE: d = '{oe: 1'b0, level: LEVEL_LOW};
         ATM_SRC_DAC:      d = '{oe: 1'b1, level: dac};
         ATM_SRC_CORR:     d = '{oe: 1'b1, level: an.corr};
         ATM_SRC_MINLVL:   d = '{oe: 1'b1, level: an.min_level};
         ATM_SRC_ADC_I:    d = '{oe: 1'b1, level: {an.adc_i, ADC_PAD}};
         ATM_SRC_ADC_Q:    d = '{oe: 1'b1, level: {an.adc_q, ADC_PAD}};
         ATM_SRC_HIGH:     d = '{oe: 1'b1, level: LEVEL_HIGH};
         ATM_SRC_LOW:      d = '{oe: 1'b1, level: LEVEL_LOW};
         ATM_SRC_TXACT:    d = '{oe: 1'b1, level: fl.tx_active ? LEVEL_HIGH : LEVEL_LOW};
         ATM_SRC_RXACT:    d = '{oe: 1'b1, level: fl.rx_active ? LEVEL_HIGH : LEVEL_LOW};
         ATM_SRC_SUBC:     d = '{oe: 1'b1, level: fl.subcarrier ? LEVEL_HIGH : LEVEL_LOW};
         ATM_SRC_TBUS:     d = '{oe: 1'b1, level: fl.test_bus_bit ? LEVEL_HIGH : LEVEL_LOW};
         // reserved and production codes float the pin
         ATM_SRC_RSV3,
         ATM_SRC_RSV7,
         ATM_SRC_PROD8,
         ATM_SRC_RSV9:     d = '{oe: 1'b0, level: LEVEL_LOW};
      endcase
      return d;
   endfunction

endpackage
`default_nettype wire

// ### verilog/atm_pin_drive.sv
`timescale 1ns/100ps
`default_nettype none
module atm_pin_drive (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   // selection
   input  wire logic [3:0]           sel,
   input  wire logic [5:0]           dac,
   input  wire atm_pkg::atm_analog_s analog,
   input  wire atm_pkg::atm_flags_s  flags,
   // pin
   output var  logic                 pin_oe_r,
   output var  logic [5:0]           pin_level_r
);

   atm_pkg::atm_drive_s drive_nxt;

   assign drive_nxt = atm_pkg::atm_decode(sel, dac, analog, flags);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_oe_r    <= 1'b0;
         pin_level_r <= atm_pkg::LEVEL_LOW;
      end else begin
         pin_oe_r    <= drive_nxt.oe;
         pin_level_r <= drive_nxt.level;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_tristate_code: assert property (@(posedge core_clk) disable iff (rst)
      sel == atm_pkg::ATM_SRC_TRISTATE |=> !pin_oe_r)
      else $error("pin driven under tristate code");
   a_dac_route: assert property (@(posedge core_clk) disable iff (rst)
      sel == atm_pkg::ATM_SRC_DAC |=> pin_oe_r && pin_level_r == $past(dac))
      else $error("dac value not on pin");
   a_const_high: assert property (@(posedge core_clk) disable iff (rst)
      sel == atm_pkg::ATM_SRC_HIGH |=> pin_oe_r && pin_level_r == atm_pkg::LEVEL_HIGH)
      else $error("constant high not driven");
   a_reserved_float: assert property (@(posedge core_clk) disable iff (rst)
      (sel == atm_pkg::ATM_SRC_RSV3 || sel == atm_pkg::ATM_SRC_RSV7 ||
       sel == atm_pkg::ATM_SRC_PROD8 || sel == atm_pkg::ATM_SRC_RSV9) |=> !pin_oe_r)
      else $error("reserved code drives pin");
   a_tbus_route: assert property (@(posedge core_clk) disable iff (rst)
      sel == atm_pkg::ATM_SRC_TBUS |=>
         pin_level_r == ($past(flags.test_bus_bit) ? atm_pkg::LEVEL_HIGH : atm_pkg::LEVEL_LOW))
      else $error("test bus bit not on pin");
   a_txact_route: assert property (@(posedge core_clk) disable iff (rst)
      sel == atm_pkg::ATM_SRC_TXACT |=>
         pin_level_r == ($past(flags.tx_active) ? atm_pkg::LEVEL_HIGH : atm_pkg::LEVEL_LOW))
      else $error("transmit indicator not on pin");

endmodule
`default_nettype wire

// ### verilog/atm_aux_test_mux.sv
`timescale 1ns/100ps
`default_nettype none

module atm_aux_test_mux (
   // clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   // register port
   input  wire logic [atm_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [atm_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                        reg_write,
   input  wire logic                        reg_read,
   output var  logic [atm_pkg::DATA_W-1:0]  reg_rdata_r,
   // analog test sources
   input  wire logic [atm_pkg::LEVEL_W-1:0] correlator_test_signal,
   input  wire logic [atm_pkg::LEVEL_W-1:0] minimum_level_signal,
   input  wire logic [atm_pkg::ADC_W-1:0]   adc_i_sample,
   input  wire logic [atm_pkg::ADC_W-1:0]   adc_q_sample,
   // framing indicators
   input  wire logic                        transmit_active_indicator,
   input  wire logic                        receive_active_indicator,
   input  wire logic                        subcarrier_detect_indicator,
   input  wire logic                        rate_is_106k,
   // test bus
   input  wire logic [atm_pkg::TBUS_W-1:0]  test_bus,
   input  wire logic [atm_pkg::TSEL_W-1:0]  test_bus_bit_selector,
   // dac values to the analog converters
   output var  logic [atm_pkg::DAC_W-1:0]   first_test_dac_value,
   output var  logic [atm_pkg::DAC_W-1:0]   second_test_dac_value,
   // auxiliary pins
   output var  logic                        first_aux_pin_oe,
   output var  logic [atm_pkg::LEVEL_W-1:0] first_aux_pin_level,
   output var  logic                        second_aux_pin_oe,
   output var  logic [atm_pkg::LEVEL_W-1:0] second_aux_pin_level
);

   ////////////////////////////////////////////////////////////////////////
   // storage

   logic [atm_pkg::DATA_W-1:0] aux_signal_select_r;
   logic [atm_pkg::DAC_W-1:0]  test_dac_one_value_r;
   logic [atm_pkg::DAC_W-1:0]  test_dac_two_value_r;
   logic [atm_pkg::DATA_W-1:0] production_reserved_a_r;
   logic [atm_pkg::DATA_W-1:0] production_reserved_b_r;
   logic [atm_pkg::DATA_W-1:0] production_reserved_c_r;
   logic [atm_pkg::DATA_W-1:0] production_reserved_d_r;

   ////////////////////////////////////////////////////////////////////////
   // address decode

   wire wr_aux_sel = reg_write && (reg_addr == atm_pkg::ADDR_AUX_SEL);
   wire wr_dac_one = reg_write && (reg_addr == atm_pkg::ADDR_DAC_ONE);
   wire wr_dac_two = reg_write && (reg_addr == atm_pkg::ADDR_DAC_TWO);
   wire wr_prod_a  = reg_write && (reg_addr == atm_pkg::ADDR_PROD_A);
   wire wr_prod_b  = reg_write && (reg_addr == atm_pkg::ADDR_PROD_B);
   wire wr_prod_c  = reg_write && (reg_addr == atm_pkg::ADDR_PROD_C);
   wire wr_prod_d  = reg_write && (reg_addr == atm_pkg::ADDR_PROD_D);

   ////////////////////////////////////////////////////////////////////////
   // field split

   wire [atm_pkg::SEL_W-1:0] first_aux_source_select =
      aux_signal_select_r[atm_pkg::SEL_FIRST_LSB +: atm_pkg::SEL_W];
   wire [atm_pkg::SEL_W-1:0] second_aux_source_select =
      aux_signal_select_r[atm_pkg::SEL_SECOND_LSB +: atm_pkg::SEL_W];

   wire [atm_pkg::DAC_W-1:0] wdata_dac = reg_wdata[atm_pkg::DAC_LSB +: atm_pkg::DAC_W];

   // live sample view; writes to this offset are dropped
   wire [atm_pkg::DATA_W-1:0] adc_view = {adc_i_sample, adc_q_sample};

   ////////////////////////////////////////////////////////////////////////
   // source bundles

   // subcarrier flag has no meaning at the base rate, so it is held low there
   wire subcarrier_gated = subcarrier_detect_indicator && !rate_is_106k;

   wire selected_test_bus_bit = test_bus[test_bus_bit_selector];

   atm_pkg::atm_analog_s analog_bus;
   atm_pkg::atm_flags_s  flag_bus;

   assign analog_bus = '{corr:      correlator_test_signal,
                         min_level: minimum_level_signal,
                         adc_i:     adc_i_sample,
                         adc_q:     adc_q_sample};

   assign flag_bus = '{tx_active:    transmit_active_indicator,
                       rx_active:    receive_active_indicator,
                       subcarrier:   subcarrier_gated,
                       test_bus_bit: selected_test_bus_bit};

   ////////////////////////////////////////////////////////////////////////
   // read mux

   logic [atm_pkg::DATA_W-1:0] rdata_nxt;

   // dac upper bits and unmapped offsets read as zero
   always_comb begin
      rdata_nxt = atm_pkg::READ_ZERO;
      if (reg_read) begin
         unique case (reg_addr)
            atm_pkg::ADDR_AUX_SEL: rdata_nxt = aux_signal_select_r;
            atm_pkg::ADDR_DAC_ONE: rdata_nxt = {2'h0, test_dac_one_value_r};
            atm_pkg::ADDR_DAC_TWO: rdata_nxt = {2'h0, test_dac_two_value_r};
            atm_pkg::ADDR_ADC:     rdata_nxt = adc_view;
            atm_pkg::ADDR_PROD_A:  rdata_nxt = production_reserved_a_r;
            atm_pkg::ADDR_PROD_B:  rdata_nxt = production_reserved_b_r;
            atm_pkg::ADDR_PROD_C:  rdata_nxt = production_reserved_c_r;
            atm_pkg::ADDR_PROD_D:  rdata_nxt = production_reserved_d_r;
            default:               rdata_nxt = atm_pkg::READ_ZERO;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         aux_signal_select_r <= atm_pkg::RST_AUX_SEL;
      end else if (wr_aux_sel) begin
         aux_signal_select_r <= reg_wdata;
      end
   end

   // dac reset is undefined in hardware; zero keeps simulation clean
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         test_dac_one_value_r <= atm_pkg::RST_DAC;
         test_dac_two_value_r <= atm_pkg::RST_DAC;
      end else begin
         if (wr_dac_one) begin
            test_dac_one_value_r <= wdata_dac;
         end
         if (wr_dac_two) begin
            test_dac_two_value_r <= wdata_dac;
         end
      end
   end

   // production registers only store; only the read mux reads them back
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         production_reserved_a_r <= atm_pkg::RST_PROD_A;
         production_reserved_b_r <= atm_pkg::RST_PROD_B;
         production_reserved_c_r <= atm_pkg::RST_PROD_C;
         production_reserved_d_r <= atm_pkg::RST_PROD_D;
      end else begin
         if (wr_prod_a) begin
            production_reserved_a_r <= reg_wdata;
         end
         if (wr_prod_b) begin
            production_reserved_b_r <= reg_wdata;
         end
         if (wr_prod_c) begin
            production_reserved_c_r <= reg_wdata;
         end
         if (wr_prod_d) begin
            production_reserved_d_r <= reg_wdata;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata_r <= atm_pkg::READ_ZERO;
      end else begin
         reg_rdata_r <= rdata_nxt;
      end
   end

   assign first_test_dac_value  = test_dac_one_value_r;
   assign second_test_dac_value = test_dac_two_value_r;

   ////////////////////////////////////////////////////////////////////////
   // pin drivers, one decoder per pin

   atm_pin_drive u_first_pin (
      .core_clk    (core_clk),
      .rst         (rst),
      .sel         (first_aux_source_select),
      .dac         (test_dac_one_value_r),
      .analog      (analog_bus),
      .flags       (flag_bus),
      .pin_oe_r    (first_aux_pin_oe),
      .pin_level_r (first_aux_pin_level)
   );

   atm_pin_drive u_second_pin (
      .core_clk    (core_clk),
      .rst         (rst),
      .sel         (second_aux_source_select),
      .dac         (test_dac_two_value_r),
      .analog      (analog_bus),
      .flags       (flag_bus),
      .pin_oe_r    (second_aux_pin_oe),
      .pin_level_r (second_aux_pin_level)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks

   a_select_reset: assert property (@(posedge core_clk)
      $fell(rst) |-> aux_signal_select_r == atm_pkg::RST_AUX_SEL
                     && !first_aux_pin_oe && !second_aux_pin_oe)
      else $error("select or pins not idle after reset");

   a_select_write: assert property (@(posedge core_clk) disable iff (rst)
      wr_aux_sel |=> first_aux_source_select == $past(reg_wdata[7:4])
                     && second_aux_source_select == $past(reg_wdata[3:0]))
      else $error("select fields misplaced");

   a_second_dac_route: assert property (@(posedge core_clk) disable iff (rst)
      wr_aux_sel && reg_wdata[3:0] == atm_pkg::ATM_SRC_DAC |=> ##1
         second_aux_pin_oe && second_aux_pin_level == $past(test_dac_two_value_r))
      else $error("second dac not on second pin");

   a_dac_one_store: assert property (@(posedge core_clk) disable iff (rst)
      wr_dac_one ##1 !wr_dac_one ##1 (reg_read && reg_addr == atm_pkg::ADDR_DAC_ONE) |=>
         reg_rdata_r == ($past(reg_wdata, 3) & 8'h3f))
      else $error("dac one readback wrong");

   a_adc_view: assert property (@(posedge core_clk) disable iff (rst)
      reg_read && reg_addr == atm_pkg::ADDR_ADC |=>
         reg_rdata_r[7:4] == $past(adc_i_sample) && reg_rdata_r[3:0] == $past(adc_q_sample))
      else $error("adc view mismatch");

   a_adc_readonly: assert property (@(posedge core_clk) disable iff (rst)
      reg_write && reg_addr == atm_pkg::ADDR_ADC |=>
         $stable(aux_signal_select_r) && $stable(test_dac_one_value_r)
         && $stable(test_dac_two_value_r))
      else $error("adc offset write changed state");

   a_prod_reset: assert property (@(posedge core_clk)
      $fell(rst) |-> production_reserved_c_r == 8'h03 && production_reserved_b_r == 8'h00
                     && production_reserved_d_r == 8'h00)
      else $error("production reset values wrong");

   a_subc_base_rate: assert property (@(posedge core_clk) disable iff (rst)
      first_aux_source_select == atm_pkg::ATM_SRC_SUBC && rate_is_106k |=>
         first_aux_pin_oe && first_aux_pin_level == atm_pkg::LEVEL_LOW)
      else $error("subcarrier flag shown at base rate");

   a_rx_route: assert property (@(posedge core_clk) disable iff (rst)
      second_aux_source_select == atm_pkg::ATM_SRC_RXACT |=>
         second_aux_pin_level ==
            ($past(receive_active_indicator) ? atm_pkg::LEVEL_HIGH : atm_pkg::LEVEL_LOW))
      else $error("receive indicator not on pin");

endmodule
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic       core_clk = 1'b0;
   logic       rst = 1'b1;
   logic [5:0] reg_addr = 6'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_write = 1'b0;
   logic       reg_read = 1'b0;
   logic [7:0] reg_rdata_r;
   logic [5:0] corr = 6'h00;
   logic [5:0] minlvl = 6'h00;
   logic [3:0] adc_i = 4'h0;
   logic [3:0] adc_q = 4'h0;
   logic       tx_act = 1'b0;
   logic       rx_act = 1'b0;
   logic       subc = 1'b0;
   logic       rate_106 = 1'b0;
   logic [7:0] tbus = 8'h00;
   logic [2:0] tsel = 3'h0;
   logic [5:0] dac_one;
   logic [5:0] dac_two;
   logic       oe_one;
   logic [5:0] lvl_one;
   logic       oe_two;
   logic [5:0] lvl_two;
   int         fail_count = 0;
   int         n_compared = 0;
   int         cycles = 0;
   int         m_reg [int];

   atm_aux_test_mux atm_aux_test_mux_i (
      .core_clk                    (core_clk),
      .rst                         (rst),
      .reg_addr                    (reg_addr),
      .reg_wdata                   (reg_wdata),
      .reg_write                   (reg_write),
      .reg_read                    (reg_read),
      .reg_rdata_r                 (reg_rdata_r),
      .correlator_test_signal      (corr),
      .minimum_level_signal        (minlvl),
      .adc_i_sample                (adc_i),
      .adc_q_sample                (adc_q),
      .transmit_active_indicator   (tx_act),
      .receive_active_indicator    (rx_act),
      .subcarrier_detect_indicator (subc),
      .rate_is_106k                (rate_106),
      .test_bus                    (tbus),
      .test_bus_bit_selector       (tsel),
      .first_test_dac_value        (dac_one),
      .second_test_dac_value       (dac_two),
      .first_aux_pin_oe            (oe_one),
      .first_aux_pin_level         (lvl_one),
      .second_aux_pin_oe           (oe_two),
      .second_aux_pin_level        (lvl_two)
   );

   always #10 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // bound on the whole run, far above the expected few hundred cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata_r, exp);
   endtask

   // model of one pin: {drive enable, level word}
   function automatic logic [6:0] pin_exp(input int code, input int dac);
      case (code)
         1:       return {1'b1, 6'(dac)};
         2:       return {1'b1, corr};
         4:       return {1'b1, minlvl};
         5:       return {1'b1, adc_i, 2'h0};
         6:       return {1'b1, adc_q, 2'h0};
         10:      return 7'h7f;
         11:      return 7'h40;
         12:      return tx_act ? 7'h7f : 7'h40;
         13:      return rx_act ? 7'h7f : 7'h40;
         14:      return (subc && !rate_106) ? 7'h7f : 7'h40;
         15:      return tbus[tsel] ? 7'h7f : 7'h40;
         default: return 7'h00;
      endcase
   endfunction

   task automatic reset_model();
      m_reg = '{'h38: 0, 'h39: 0, 'h3a: 0, 'h3c: 0, 'h3d: 0, 'h3e: 3, 'h3f: 0};
   endtask

   task automatic rand_src();
      corr     <= 6'($urandom);
      minlvl   <= 6'($urandom);
      adc_i    <= 4'($urandom);
      adc_q    <= 4'($urandom);
      tx_act   <= 1'($urandom);
      rx_act   <= 1'($urandom);
      subc     <= 1'($urandom);
      rate_106 <= 1'($urandom);
      tbus     <= 8'($urandom);
      tsel     <= 3'($urandom);
   endtask

   task automatic chk_regs();
      rd(6'h38, 8'(m_reg['h38]));
      rd(6'h39, 8'(m_reg['h39]));
      rd(6'h3a, 8'(m_reg['h3a]));
      rd(6'h3c, 8'(m_reg['h3c]));
      rd(6'h3d, 8'(m_reg['h3d]));
      rd(6'h3e, 8'(m_reg['h3e]));
      rd(6'h3f, 8'(m_reg['h3f]));
      rd(6'h00, 8'h00);
   endtask

   task automatic chk_pins();
      int s;
      s = m_reg['h38];
      chk({oe_one, lvl_one}, pin_exp(s >> 4, m_reg['h39]));
      chk({oe_two, lvl_two}, pin_exp(s & 15, m_reg['h3a]));
      chk(dac_one, m_reg['h39]);
      chk(dac_two, m_reg['h3a]);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      int b;
      void'($urandom(34));
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      reset_model();
      chk_regs();
      chk_pins();
      // every code on each pin, the second pin shifted by 0, 5 and 10 codes
      for (int rep = 0; rep < 3; rep++) begin
         for (int c = 0; c < 16; c++) begin
            b = $urandom;
            wr(6'h39, 8'(b));
            m_reg['h39] = b & 'h3f;
            wr(6'h3a, 8'(b >> 8));
            m_reg['h3a] = (b >> 8) & 'h3f;
            rand_src();
            m_reg['h38] = (c << 4) | ((c + rep * 5) & 15);
            wr(6'h38, 8'(m_reg['h38]));
            repeat (2) @(posedge core_clk);
            #1;
            chk_pins();
         end
      end
      // adc view is read-only and follows the live samples
      wr(6'h3b, 8'h5a);
      rand_src();
      repeat (2) @(posedge core_clk);
      rd(6'h3b, {adc_i, adc_q});
      for (int a = 'h3c; a <= 'h3f; a++) begin
         b = $urandom & 'hff;
         wr(6'(a), 8'(b));
         m_reg[a] = b;
      end
      // subcarrier flag at the base rate is held low on both pins
      subc     <= 1'b1;
      rate_106 <= 1'b1;
      m_reg['h38] = 'hee;
      wr(6'h38, 8'hee);
      repeat (2) @(posedge core_clk);
      #1;
      chk_pins();
      wr(6'h39, 8'hff);
      m_reg['h39] = 'h3f;
      rd(6'h39, 8'h3f);
      chk_regs();
      // second reset mid-run returns documented values
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      reset_model();
      #1;
      chk({oe_one, oe_two}, 2'b00);
      chk_regs();
      summarize();
   end
endmodule
`default_nettype wire
